// File: rtl/xmem_pkg.sv
// constants, field positions and state codes for the external memory interface configuration block
// assumes a cpu-side i/o register port and a single system clock
package xmem_pkg;
  // register offsets on the i/o port
  localparam logic [7:0] mcu_control_off       = 8'h35;
  localparam logic [7:0] ext_mem_control_b_off = 8'h6c;
  localparam logic [7:0] ext_mem_control_a_off = 8'h6d;
  // values after reset
  localparam logic [7:0] mcu_control_rst       = 8'h00;
  localparam logic [7:0] ext_mem_control_a_rst = 8'h00;
  localparam logic [7:0] ext_mem_control_b_rst = 8'h00;
  // implemented bits of each register
  localparam logic [7:0] mcu_control_mask      = 8'hc0;
  localparam logic [7:0] ext_mem_control_a_mask = 8'h7e;
  localparam logic [7:0] ext_mem_control_b_mask = 8'h87;
  // field positions
  localparam int ext_mem_enable_bit      = 7;
  localparam int upper_wait_low_bit_pos  = 6;
  localparam int sector_limit_lsb        = 4;
  localparam int lower_wait_lsb          = 2;
  localparam int upper_wait_high_bit_pos = 1;
  localparam int bus_keeper_enable_bit   = 7;
  localparam int high_addr_mask_lsb      = 0;
  // address bits that select the 0x2000-wide sector boundary
  localparam int sector_addr_lsb         = 13;
  // mask value that frees the whole high port
  localparam logic [2:0] release_all     = 3'h7;
  localparam logic [3:0] high_addr_width = 4'h8;
  // wait code that adds an idle cycle after a write strobe
  localparam logic [1:0] wait_code_gap   = 2'h3;
  // access sequencer states, one-hot
  typedef enum logic [4:0] {
    st_idle   = 5'h01,
    st_addr   = 5'h02,
    st_strobe = 5'h04,
    st_gap    = 5'h08,
    st_done   = 5'h10
  } seq_state_t;
endpackage

// File: rtl/ext_memory_if_config.sv
// external memory interface: configuration registers, sector wait-states, pin muxing and bus keeper
// assumes the cpu asks only for addresses in external space (0x1100 and up) and holds
// a request until done; port logic supplies normal port values and directions
`timescale 1ns/1ps
module ext_memory_if_config (
  input  wire logic        sys_clk,         // system clock, 50 mhz
  input  wire logic        rst,             // synchronous reset, active high
  input  wire logic        compat_mode,     // legacy compatibility mode strap
  input  wire logic [7:0]  io_addr,         // register port address
  input  wire logic        io_we,           // register write strobe
  input  wire logic [7:0]  io_wdata,        // register write data
  output logic      [7:0]  io_rdata,        // register read data
  input  wire logic        cpu_req,         // external access request
  input  wire logic        cpu_we,          // access is a write
  input  wire logic [15:0] cpu_addr,        // access address
  input  wire logic [7:0]  cpu_wdata,       // write data
  output logic      [7:0]  cpu_rdata,       // read data
  output logic             cpu_done,        // access finished pulse
  output logic             busy,            // access in progress
  input  wire logic [7:0]  porta_out,       // normal port value for muxed lines
  input  wire logic [7:0]  porta_dir,       // normal port direction, 1 = output
  input  wire logic [7:0]  portc_out,       // normal port value for high lines
  input  wire logic [7:0]  portc_dir,       // normal port direction, 1 = output
  input  wire logic [7:0]  muxed_addr_data_lines_in,  // muxed line level
  output logic      [7:0]  muxed_addr_data_lines_out, // muxed line drive value
  output logic      [7:0]  muxed_addr_data_lines_oe_n, // low while driven
  output logic      [7:0]  high_addr_lines_out,       // high line drive value
  output logic      [7:0]  high_addr_lines_oe_n,      // low while driven
  output logic             ale,             // address latch strobe
  output logic             wr_n,            // write strobe, active low
  output logic             rd_n,            // read strobe, active low
  output logic             strobe_oe_n,     // low while strobes are owned
  output logic             keeper_active,   // keeper holds muxed lines
  output logic      [7:0]  keeper_level     // level held by keeper
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0]            mcu_r;     // mcu control
    logic [7:0]            xa_r;      // external memory control a
    logic [7:0]            xb_r;      // external memory control b
    xmem_pkg::seq_state_t  st_r;      // sequencer state
    logic [1:0]            cnt_r;     // wait cycles left
    logic [1:0]            code_r;    // wait code of this access
    logic [15:0]           addr_r;    // latched address
    logic [7:0]            wdata_r;   // latched write data
    logic                  we_r;      // latched direction
    logic [7:0]            rdata_r;   // captured read data
    logic [7:0]            s1_r;      // muxed line sync stage 1
    logic [7:0]            s2_r;      // muxed line sync stage 2
    logic [7:0]            keep_r;    // keeper level
    logic [7:0]            iord_r;    // register read data
  } state_t;

  state_t cur_r;                      // registered state
  state_t cur_nxt;                    // next state

  logic       en;                     // interface enable
  logic [1:0] sel_code;               // wait code for a new access
  logic [2:0] limit;                  // sector limit code
  logic [2:0] hmask;                  // high address release mask
  logic [3:0] hbits;                  // number of high address lines used
  logic       drive_ad;               // interface drives muxed lines
  logic [7:0] ad_val;                 // interface value on muxed lines

  ////////////////////////////////////////////////////////////////////////////
  // decoding of the configuration
  always_comb begin
    en    = cur_r.mcu_r[xmem_pkg::ext_mem_enable_bit];
    limit = cur_r.xa_r[xmem_pkg::sector_limit_lsb +: 3];
    hmask = cur_r.xb_r[xmem_pkg::high_addr_mask_lsb +: 3];
    if (compat_mode) begin
      sel_code = {1'b0, cur_r.mcu_r[xmem_pkg::upper_wait_low_bit_pos]};
    end else if (cpu_addr[15:xmem_pkg::sector_addr_lsb] < limit) begin
      sel_code = cur_r.xa_r[xmem_pkg::lower_wait_lsb +: 2];
    end else begin
      sel_code = {cur_r.xa_r[xmem_pkg::upper_wait_high_bit_pos],
                  cur_r.mcu_r[xmem_pkg::upper_wait_low_bit_pos]};
    end
    if (hmask == xmem_pkg::release_all) begin
      hbits = 4'h0;
    end else begin
      hbits = xmem_pkg::high_addr_width - {1'b0, hmask};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: registers, sequencer, synchroniser, keeper
  always_comb begin
    cur_nxt = cur_r;
    // muxed lines pass two flops before use
    cur_nxt.s1_r = muxed_addr_data_lines_in;
    cur_nxt.s2_r = cur_r.s1_r;
    // register writes, unimplemented bits stay zero
    if (io_we) begin
      if (io_addr == xmem_pkg::mcu_control_off) begin
        cur_nxt.mcu_r = io_wdata & xmem_pkg::mcu_control_mask;
      end else if (io_addr == xmem_pkg::ext_mem_control_a_off) begin
        cur_nxt.xa_r = io_wdata & xmem_pkg::ext_mem_control_a_mask;
      end else if (io_addr == xmem_pkg::ext_mem_control_b_off) begin
        cur_nxt.xb_r = io_wdata & xmem_pkg::ext_mem_control_b_mask;
      end
    end
    // register reads, other addresses read zero
    if (io_addr == xmem_pkg::mcu_control_off) begin
      cur_nxt.iord_r = cur_r.mcu_r;
    end else if (io_addr == xmem_pkg::ext_mem_control_a_off) begin
      cur_nxt.iord_r = cur_r.xa_r;
    end else if (io_addr == xmem_pkg::ext_mem_control_b_off) begin
      cur_nxt.iord_r = cur_r.xb_r;
    end else begin
      cur_nxt.iord_r = 8'h00;
    end
    // access sequencer
    case (cur_r.st_r)
      xmem_pkg::st_idle: begin
        if (cpu_req && en) begin
          cur_nxt.st_r    = xmem_pkg::st_addr;
          cur_nxt.addr_r  = cpu_addr;
          cur_nxt.wdata_r = cpu_wdata;
          cur_nxt.we_r    = cpu_we;
          cur_nxt.code_r  = sel_code;
        end
      end
      xmem_pkg::st_addr: begin
        cur_nxt.st_r  = xmem_pkg::st_strobe;
        cur_nxt.cnt_r = (cur_r.code_r == xmem_pkg::wait_code_gap) ? 2'h2 : cur_r.code_r;
      end
      xmem_pkg::st_strobe: begin
        if (cur_r.cnt_r != 2'h0) begin
          cur_nxt.cnt_r = cur_r.cnt_r - 2'h1;
        end else begin
          // reads hold two cycles so the synchronised line catches up
          cur_nxt.cnt_r = cur_r.we_r ? 2'h0 : 2'h1;
          if ((cur_r.code_r == xmem_pkg::wait_code_gap) || !cur_r.we_r) begin
            cur_nxt.st_r = xmem_pkg::st_gap;
          end else begin
            cur_nxt.st_r = xmem_pkg::st_done;
          end
        end
      end
      xmem_pkg::st_gap: begin
        if (cur_r.cnt_r != 2'h0) begin
          cur_nxt.cnt_r = cur_r.cnt_r - 2'h1;
        end else begin
          // sync stage 2 now holds the line level of the last strobe cycle
          if (!cur_r.we_r) begin
            cur_nxt.rdata_r = cur_r.s2_r;
          end
          cur_nxt.st_r = xmem_pkg::st_done;
        end
      end
      xmem_pkg::st_done: begin
        cur_nxt.st_r = xmem_pkg::st_idle;
      end
      default: begin
        cur_nxt.st_r = xmem_pkg::st_idle;
      end
    endcase
    if (muxed_addr_data_lines_oe_n == 8'h00) begin
      cur_nxt.keep_r = muxed_addr_data_lines_out;
    end else begin
      cur_nxt.keep_r = cur_r.keep_r;
    end
    // reset values
    if (rst) begin
      cur_nxt.mcu_r   = xmem_pkg::mcu_control_rst;
      cur_nxt.xa_r    = xmem_pkg::ext_mem_control_a_rst;
      cur_nxt.xb_r    = xmem_pkg::ext_mem_control_b_rst;
      cur_nxt.st_r    = xmem_pkg::st_idle;
      cur_nxt.cnt_r   = 2'h0;
      cur_nxt.code_r  = 2'h0;
      cur_nxt.addr_r  = 16'h0000;
      cur_nxt.wdata_r = 8'h00;
      cur_nxt.we_r    = 1'b0;
      cur_nxt.rdata_r = 8'h00;
      cur_nxt.s1_r    = 8'h00;
      cur_nxt.s2_r    = 8'h00;
      cur_nxt.keep_r  = 8'h00;
      cur_nxt.iord_r  = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk) begin
    cur_r <= cur_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin multiplexing
  always_comb begin
    // address in address phase, write data in strobe phase
    drive_ad = (cur_r.st_r == xmem_pkg::st_addr) ||
               ((cur_r.st_r == xmem_pkg::st_strobe) && cur_r.we_r);
    ad_val   = (cur_r.st_r == xmem_pkg::st_addr) ? cur_r.addr_r[7:0] : cur_r.wdata_r;
    if (en) begin
      muxed_addr_data_lines_out  = ad_val;
      muxed_addr_data_lines_oe_n = drive_ad ? 8'h00 : 8'hff;
      ale         = (cur_r.st_r == xmem_pkg::st_addr);
      wr_n        = !((cur_r.st_r == xmem_pkg::st_strobe) && cur_r.we_r);
      rd_n        = !((cur_r.st_r == xmem_pkg::st_strobe) && !cur_r.we_r);
      strobe_oe_n = 1'b0;
    end else begin
      muxed_addr_data_lines_out  = porta_out;
      muxed_addr_data_lines_oe_n = ~porta_dir;
      ale         = 1'b0;
      wr_n        = 1'b1;
      rd_n        = 1'b1;
      strobe_oe_n = 1'b1;
    end
    for (int i = 0; i < 8; i++) begin
      if (en && (i < int'(hbits))) begin
        high_addr_lines_out[i]  = cur_r.addr_r[8 + i];
        high_addr_lines_oe_n[i] = 1'b0;
      end else begin
        high_addr_lines_out[i]  = portc_out[i];
        high_addr_lines_oe_n[i] = !portc_dir[i];
      end
    end
    keeper_active = cur_r.xb_r[xmem_pkg::bus_keeper_enable_bit] && (muxed_addr_data_lines_oe_n != 8'h00);
    keeper_level  = cur_r.keep_r;
    // cpu side answers
    io_rdata  = cur_r.iord_r;
    cpu_rdata = cur_r.rdata_r;
    cpu_done  = (cur_r.st_r == xmem_pkg::st_done);
    busy      = (cur_r.st_r != xmem_pkg::st_idle);
  end

endmodule

// File: tb/xmem_sva.sv
// checker for the external memory configuration block
// assumes it is bound onto the design top and sees its ports only
`timescale 1ns/1ps
module xmem_chk (
  input wire logic        sys_clk, rst, compat_mode, io_we, ale, wr_n, rd_n,
  input wire logic        strobe_oe_n, cpu_done, keeper_active, busy,
  input wire logic [7:0]  io_addr, io_wdata, porta_out, porta_dir, portc_out, portc_dir, cpu_wdata,
  input wire logic [7:0]  keeper_level,
  input wire logic [7:0]  muxed_addr_data_lines_out, muxed_addr_data_lines_oe_n,
  input wire logic [7:0]  high_addr_lines_out, high_addr_lines_oe_n,
  input wire logic [15:0] cpu_addr
);
  logic [7:0] m_r, a_r, b_r, used, cnt_r, scnt_r; // register shadows, counters
  logic [1:0] code;                               // wait code of current access
  logic       rd_r;                               // current access is a read
  logic [7:0] exp_len;                            // expected cycles from latch strobe to done
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // shadow register writes, count cycles since the latch strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      m_r <= 8'h00;
      a_r <= 8'h00;
      b_r <= 8'h00;
      cnt_r <= 8'h00;
      scnt_r <= 8'h00;
      rd_r <= 1'b0;
    end else begin
      if (io_we && io_addr == 8'h35) m_r <= io_wdata;
      if (io_we && io_addr == 8'h6d) a_r <= io_wdata;
      if (io_we && io_addr == 8'h6c) b_r <= io_wdata;
      cnt_r <= ale ? 8'h01 : cnt_r + 8'h01;
      scnt_r <= ale ? 8'h00 : scnt_r + {7'h00, !(rd_n && wr_n)};
      rd_r <= ale ? 1'b0 : (rd_r || !rd_n);
    end
  end
  // expected wait code and driven high lines
  always_comb begin
    if (compat_mode) code = {1'b0, m_r[6]};
    else if (a_r[6:4] != 3'h0 && cpu_addr[15:13] < a_r[6:4]) code = a_r[3:2];
    else code = {a_r[1], m_r[6]};
    // reads wait two more cycles for the synchronised line, one more with wait code 3
    if (code == 2'h3) exp_len = rd_r ? 8'h06 : 8'h05;
    else exp_len = {6'h00, code} + (rd_r ? 8'h04 : 8'h02);
    for (int i = 0; i < 8; i++) used[i] = (b_r[2:0] != 3'h7) && (i < 8 - b_r[2:0]);
  end
  a_strobe_owned: assert property (strobe_oe_n == !m_r[7]) else $error("strobe ownership wrong");
  a_port_passthru: assert property (!m_r[7] |-> muxed_addr_data_lines_out == porta_out
    && muxed_addr_data_lines_oe_n == ~porta_dir && high_addr_lines_out == portc_out
    && high_addr_lines_oe_n == ~portc_dir) else $error("port values not passed");
  a_addr_phase: assert property (ale |-> muxed_addr_data_lines_oe_n == 8'h00
    && muxed_addr_data_lines_out == cpu_addr[7:0] && ((high_addr_lines_out ^ cpu_addr[15:8]) & used) == 8'h00
    && (high_addr_lines_oe_n & used) == 8'h00) else $error("address phase wrong");
  a_high_release: assert property (m_r[7] |-> (high_addr_lines_oe_n & ~used) == (~portc_dir & ~used)
    && (high_addr_lines_out & ~used) == (portc_out & ~used)) else $error("released high lines wrong");
  a_write_drive: assert property (!wr_n |-> muxed_addr_data_lines_oe_n == 8'h00
    && muxed_addr_data_lines_out == cpu_wdata) else $error("write data not driven");
  a_read_release: assert property (!rd_n |-> muxed_addr_data_lines_oe_n == 8'hff) else $error("read bus driven");
  a_done_latency: assert property (cpu_done |-> cnt_r == exp_len)
    else $error("access length wrong");
  a_strobe_width: assert property (cpu_done |-> scnt_r == ((code == 2'h3) ? 8'h03 : {6'h00, code} + 8'h01))
    else $error("strobe width wrong");
  a_done_bound: assert property ($rose(ale) |-> ##[2:6] cpu_done) else $error("access never ends");
  a_keeper_on: assert property (keeper_active == (b_r[7] && muxed_addr_data_lines_oe_n != 8'h00))
    else $error("keeper state wrong");
  a_keep_level: assert property (muxed_addr_data_lines_oe_n == 8'h00 |=>
    keeper_level == $past(muxed_addr_data_lines_out)) else $error("keeper level not captured");
  a_keep_hold: assert property (muxed_addr_data_lines_oe_n != 8'h00 |=>
    $stable(keeper_level)) else $error("keeper level moved");
  a_busy_span: assert property (ale || cpu_done |-> busy) else $error("busy low in access");
  c_read_wait: cover property (cpu_done && rd_r && code != 2'h0);
  c_gap: cover property (cpu_done && code == 2'h3);
  c_keep_off: cover property (keeper_active && !m_r[7]);
  c_lower: cover property ($rose(ale) && a_r[6:4] != 3'h0 && cpu_addr[15:13] < a_r[6:4]);
endmodule
bind ext_memory_if_config xmem_chk u_chk (.*);

// File: tb/sram_model.sv
// external sram stand-in on the muxed bus, 256 bytes by low address
// assumes the latch strobe and active-low strobes of the block
`timescale 1ns/1ps
module sram_model (
  input  wire logic       clk,     // system clock
  input  wire logic       ale,     // address latch strobe
  input  wire logic       wr_n,    // write strobe
  input  wire logic       rd_n,    // read strobe
  input  wire logic [7:0] ad_out,  // block drive value
  input  wire logic [7:0] ad_oe_n, // block enables, low = driven
  output logic      [7:0] ad_in    // resolved line level
);
  logic [7:0] mem [256];  // storage
  logic [7:0] addr_q;     // latched low address
  logic [7:0] last_q = 8'h5a; // previous line level
  // latch address, store writes, remember the line
  always @(posedge clk) begin
    if (ale) addr_q <= ad_out;
    if (!wr_n) mem[addr_q] <= ad_out;
    last_q <= ad_in;
  end
  // memory drives only under read strobe; a floating line wanders
  always_comb ad_in = (ad_out & ~ad_oe_n) | ((!rd_n ? mem[addr_q] : ~last_q) & ad_oe_n);
endmodule

// File: tb/tb_top.sv
// self-checking bench for the external memory configuration block
// assumes the design, the sram stand-in and the checker are compiled first
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk, rst, compat_mode, io_we, cpu_req, cpu_we, cpu_done, busy;
  logic        ale, wr_n, rd_n, strobe_oe_n, keeper_active;
  logic [7:0]  io_addr, io_wdata, io_rdata, cpu_wdata, cpu_rdata, keeper_level, d;
  logic [7:0]  porta_out, porta_dir, portc_out, portc_dir, ad_in, ad_out, ad_oe_n, hi_out, hi_oe_n;
  logic [7:0]  sh_m, sh_a, sh_b, shadow [256], offs [3], msk [3];
  logic [15:0] cpu_addr, a;
  int          num_errors, checks;
  ext_memory_if_config u_dut (.*, .muxed_addr_data_lines_in(ad_in), .muxed_addr_data_lines_out(ad_out),
    .muxed_addr_data_lines_oe_n(ad_oe_n), .high_addr_lines_out(hi_out), .high_addr_lines_oe_n(hi_oe_n));
  sram_model u_mem (.clk(sys_clk), .ale(ale), .wr_n(wr_n), .rd_n(rd_n), .ad_out(ad_out),
    .ad_oe_n(ad_oe_n), .ad_in(ad_in));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk_data(input string what, input logic [7:0] exp, got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_lat(input string what, input int exp, got);
    checks++;
    if (got != exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] ad, dt);
    io_addr = ad;
    io_wdata = dt;
    io_we = 1'b1;
    @(negedge sys_clk);
    io_we = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rd_reg(input logic [7:0] ad, exp);
    io_addr = ad;
    @(negedge sys_clk);
    chk_data("register read", exp, io_rdata);
  endtask
  // wait code the access should get
  function automatic logic [1:0] wcode(input logic [15:0] ad);
    if (compat_mode) return {1'b0, sh_m[6]};
    if (sh_a[6:4] != 3'h0 && ad[15:13] < sh_a[6:4]) return sh_a[3:2];
    return {sh_a[1], sh_m[6]};
  endfunction
  task automatic xfer(input logic we, input logic [15:0] ad, input logic [7:0] dt);
    int n;
    logic [1:0] c;
    c = wcode(ad);
    n = 0;
    cpu_we = we;
    cpu_addr = ad;
    cpu_wdata = dt;
    cpu_req = 1'b1;
    while (cpu_done !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    cpu_req = 1'b0;
    chk_lat("access latency", we ? ((c == 2'h3) ? 6 : 3 + c) : ((c == 2'h3) ? 7 : 5 + c), n);
    chk_data("busy at done", 8'h01, {7'h00, busy});
    if (!we) chk_data("read data", shadow[ad[7:0]], cpu_rdata);
    if (we) shadow[ad[7:0]] = dt;
    @(negedge sys_clk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    results();
  end
  initial begin
    {rst, compat_mode, io_we, cpu_req, cpu_we} = 5'h10;
    {io_addr, io_wdata, cpu_wdata, porta_out, porta_dir, portc_out, portc_dir} = '0;
    {cpu_addr, sh_m, sh_a, sh_b} = '0;
    offs = '{xmem_pkg::mcu_control_off, xmem_pkg::ext_mem_control_a_off, xmem_pkg::ext_mem_control_b_off};
    msk = '{xmem_pkg::mcu_control_mask, xmem_pkg::ext_mem_control_a_mask, xmem_pkg::ext_mem_control_b_mask};
    void'($urandom(39));
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    foreach (offs[j]) begin
      rd_reg(offs[j], 8'h00);
      wr_reg(offs[j], 8'hff);
      rd_reg(offs[j], msk[j]);
      wr_reg(offs[j], 8'h00);
    end
    rd_reg(8'h36, 8'h00);
    $display("register test done");
    porta_out = $urandom;
    porta_dir = 8'h0f;
    wr_reg(offs[2], 8'h80);
    cpu_addr = 16'h2000;
    cpu_req = 1'b1;
    repeat (8) begin
      @(negedge sys_clk);
      chk_data("disabled access", 8'h00, {6'h00, busy, cpu_done});
    end
    cpu_req = 1'b0;
    chk_data("keeper", 8'h01, {7'h00, keeper_active});
    chk_data("port value", porta_out, ad_out);
    $display("disabled test done");
    for (int i = 0; i < 64; i++) begin
      sh_a = $urandom & 8'h7e;
      sh_m = 8'h80 | ($urandom & 8'h40);
      sh_b = $urandom & 8'h87;
      if (i % 4 == 0) sh_a[6:4] = 3'h0;
      if (i % 4 == 1) sh_a[6:4] = 3'(i % 7) + 3'h1;
      compat_mode = (i >= 52);
      wr_reg(offs[0], sh_m);
      wr_reg(offs[1], sh_a);
      wr_reg(offs[2], sh_b);
      {porta_out, porta_dir, portc_out, portc_dir} = $urandom;
      a = 16'h1100 + 16'($urandom % 32'hef00);
      if (i % 4 == 1) a = {sh_a[6:4], 13'h0000} - {15'h0000, i[3]};
      d = $urandom;
      xfer(1'b1, a, d);
      xfer(1'b0, a, d);
    end
    $display("access test done");
    wr_reg(offs[0], 8'h00);
    chk_data("port value", porta_out, ad_out);
    results();
  end
endmodule
